/* design/pffs_pkg.sv */
package pffs_pkg;

	// Status register field positions
	localparam int STAT_W         = 8;
	localparam int BIT_PORT1_ERR  = 7;
	localparam int BIT_DISCH_FAIL = 6;
	localparam int BIT_JUST_RESET = 5;
	localparam int BIT_LOW_VOLT   = 4;
	localparam int BIT_OVERTEMP   = 3;
	localparam int BIT_SUPPLY_OV  = 2;

	// Reset values
	localparam logic       JUST_RESET_RST = 1'b1;
	localparam logic       FAULT_RST      = 1'b0;
	localparam logic [7:0] STAT_RST       = 8'h00;

	// Latency of a status read, in clock cycles
	localparam int RD_LATENCY = 1;

	typedef enum logic [0:0] {
		PFFS_ACTIVE,
		PFFS_ERROR
	} pffs_state_t;

endpackage

/* design/pffs_flags.sv */
`timescale 1ns/1ps
// Behaviour
// - Just-reset flag set at power-up, cleared by read/enable toggle
// - Just-reset flag never raises an alert
// - Just-reset flag held unchanged during sleep
// - Low port 1 voltage sets low-voltage flag
// - Low-voltage flag: port 1 alert, Error state
// - Faults clear on read if gone, or error clear
// - Die over-temperature sets flag, enters Error state
// - Overtemp or overvoltage asserts both alert outputs
// - Supply overvoltage sets flag, enters Error state
// - Discharge failure sets flag, port 1 alert, Error
module pffs_flags
	import pffs_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              port1_low_voltage_in,
	input  wire logic              die_overtemp_in,
	input  wire logic              supply_overvoltage_in,
	input  wire logic              port1_discharge_fail_in,
	input  wire logic              power_enable_control,
	input  wire logic              sleep_mode,
	input  wire logic              status_rd,
	input  wire logic              port1_error_clear,
	output logic [STAT_W-1:0]      status_rd_data,
	output logic                   status_rd_valid,
	output logic                   port1_error_bit,
	output logic                   alert1_o,
	output logic                   alert1_oe,
	output logic                   alert2_o,
	output logic                   alert2_oe
);

	// Two-stage synchronisers for pin-level inputs
	logic [4:0] sync1_q;
	logic [4:0] sync2_q;
	logic [4:0] sync1_d;

	always_comb begin
		sync1_d = {power_enable_control, port1_discharge_fail_in,
		           supply_overvoltage_in, die_overtemp_in,
		           port1_low_voltage_in};
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 5'h00;
			sync2_q <= 5'h00;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync1_q;
		end
	end

	logic low_volt_c;
	logic overtemp_c;
	logic supply_ov_c;
	logic disch_c;
	logic power_enable_control_s;

	assign low_volt_c  = sync2_q[0];
	assign overtemp_c  = sync2_q[1];
	assign supply_ov_c = sync2_q[2];
	assign disch_c     = sync2_q[3];
	assign power_enable_control_s    = sync2_q[4];

	// Flag state
	logic        just_reset_q;
	logic        just_reset_d;
	logic        low_volt_q;
	logic        low_volt_d;
	logic        overtemp_q;
	logic        overtemp_d;
	logic        supply_ov_q;
	logic        supply_ov_d;
	logic        disch_q;
	logic        disch_d;
	logic        power_enable_control_prev_q;
	logic        power_enable_control_prev_d;
	pffs_state_t state_q;
	pffs_state_t state_d;
	logic [7:0]  rd_data_q;
	logic [7:0]  rd_data_d;
	logic        rd_valid_q;
	logic        rd_valid_d;

	logic pwr_toggle;
	logic any_fault_d;
	logic any_cause;

	// Sticky fault: a live cause wins over every clear
	function automatic logic fault_next(input logic cur, input logic cause,
	                                    input logic rd, input logic eclr);
		logic clr;
		clr = rd | eclr;
		fault_next = cause | (cur & ~clr);
	endfunction

	function automatic logic [7:0] pack_status(input logic err,
	                                           input logic dsc,
	                                           input logic jrs,
	                                           input logic lv,
	                                           input logic ot,
	                                           input logic ov);
		logic [7:0] v;
		v = STAT_RST;
		v[BIT_PORT1_ERR]  = err;
		v[BIT_DISCH_FAIL] = dsc;
		v[BIT_JUST_RESET] = jrs;
		v[BIT_LOW_VOLT]   = lv;
		v[BIT_OVERTEMP]   = ot;
		v[BIT_SUPPLY_OV]  = ov;
		pack_status = v;
	endfunction

	assign pwr_toggle = power_enable_control_s ^ power_enable_control_prev_q;
	assign any_cause  = low_volt_c | overtemp_c | supply_ov_c | disch_c;

	always_comb begin
		power_enable_control_prev_d = power_enable_control_s;
		// set at reset, cleared by read or toggle
		if (sleep_mode) begin
			just_reset_d = just_reset_q;
		end else if (status_rd || pwr_toggle) begin
			just_reset_d = 1'b0;
		end else begin
			just_reset_d = just_reset_q;
		end
		// low port 1 voltage sets flag
		// clear on read once cause gone
		low_volt_d  = fault_next(low_volt_q, low_volt_c, status_rd,
		                         port1_error_clear);
		overtemp_d  = fault_next(overtemp_q, overtemp_c, status_rd,
		                         port1_error_clear);
		supply_ov_d = fault_next(supply_ov_q, supply_ov_c, status_rd,
		                         port1_error_clear);
		disch_d     = fault_next(disch_q, disch_c, status_rd,
		                         port1_error_clear);
		any_fault_d = low_volt_d | overtemp_d | supply_ov_d | disch_d;
		rd_valid_d = status_rd;
		if (status_rd) begin
			rd_data_d = pack_status(state_q == PFFS_ERROR, disch_q,
			                        just_reset_q, low_volt_q,
			                        overtemp_q, supply_ov_q);
		end else begin
			rd_data_d = rd_data_q;
		end
	end

	// Error state tracking
	always_comb begin
		state_d = state_q;
		case (state_q)
			PFFS_ACTIVE: begin
				if (any_fault_d) begin
					state_d = PFFS_ERROR;
				end
			end
			PFFS_ERROR: begin
				if (port1_error_clear && !any_cause) begin
					state_d = PFFS_ACTIVE;
				end
			end
			default: begin
				state_d = PFFS_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			just_reset_q  <= JUST_RESET_RST;
			low_volt_q    <= FAULT_RST;
			overtemp_q    <= FAULT_RST;
			supply_ov_q   <= FAULT_RST;
			disch_q       <= FAULT_RST;
			power_enable_control_prev_q <= 1'b0;
			state_q       <= PFFS_ACTIVE;
			rd_data_q     <= STAT_RST;
			rd_valid_q    <= 1'b0;
		end else begin
			just_reset_q  <= just_reset_d;
			low_volt_q    <= low_volt_d;
			overtemp_q    <= overtemp_d;
			supply_ov_q   <= supply_ov_d;
			disch_q       <= disch_d;
			power_enable_control_prev_q <= power_enable_control_prev_d;
			state_q       <= state_d;
			rd_data_q     <= rd_data_d;
			rd_valid_q    <= rd_valid_d;
		end
	end

	// Alert outputs, open drain pulling low
	logic alert1_drive;
	logic alert2_drive;

	// port 1 faults drive alert 1 only
	assign alert1_drive = low_volt_q | disch_q | overtemp_q | supply_ov_q;
	// thermal and supply faults drive both
	assign alert2_drive = overtemp_q | supply_ov_q;

	assign alert1_o        = 1'b0;
	assign alert2_o        = 1'b0;
	assign alert1_oe       = alert1_drive;
	assign alert2_oe       = alert2_drive;
	assign port1_error_bit = (state_q == PFFS_ERROR);
	assign status_rd_data  = rd_data_q;
	assign status_rd_valid = rd_valid_q;

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	sequence rd_idle_s;
		!status_rd && !port1_error_clear;
	endsequence

	sequence read_s;
		status_rd ##1 status_rd_valid;
	endsequence

	just_reset_clr_a: assert property (
		status_rd && !sleep_mode |=> !just_reset_q)
		else $error("just-reset flag survived a read");

	reset_no_alert_a: assert property (
		just_reset_q && !low_volt_q && !disch_q && !overtemp_q
		&& !supply_ov_q |-> !alert1_oe && !alert2_oe)
		else $error("alert raised by just-reset flag alone");

	sleep_keeps_a: assert property (
		sleep_mode |=> just_reset_q == $past(just_reset_q))
		else $error("just-reset flag changed in sleep");

	low_volt_set_a: assert property (
		port1_low_voltage_in |-> ##3 low_volt_q [*2])
		else $error("low-voltage flag not set");

	low_volt_alert_a: assert property (
		low_volt_q && !overtemp_q && !supply_ov_q && !port1_error_clear |->
		alert1_oe && !alert2_oe ##1 port1_error_bit)
		else $error("low-voltage alert or Error state wrong");

	fault_sticky_a: assert property (
		overtemp_q ##0 rd_idle_s |=> overtemp_q)
		else $error("fault flag cleared without a clear");

	fault_clear_a: assert property (
		status_rd && !overtemp_c && !sync1_d[1] |=> !overtemp_q)
		else $error("fault flag held after read with cause gone");

	overtemp_err_a: assert property (
		die_overtemp_in ##2 1'b1 |=> overtemp_q ##1 port1_error_bit)
		else $error("over-temperature not flagged");

	both_alert_a: assert property (
		overtemp_q || supply_ov_q |-> alert1_oe && alert2_oe)
		else $error("thermal or supply fault missing an alert");

	supply_ov_err_a: assert property (
		supply_ov_c |=> supply_ov_q ##1 port1_error_bit)
		else $error("supply overvoltage not flagged");

	disch_alert_a: assert property (
		disch_c |=> disch_q && alert1_oe ##1 port1_error_bit)
		else $error("discharge failure not flagged");

	read_data_a: assert property (
		status_rd ##0 (low_volt_q && !low_volt_c) |-> read_s ##0
		status_rd_data[BIT_LOW_VOLT])
		else $error("read lost the pre-clear flag value");

endmodule

/* tb/pffs_host.sv */
`timescale 1ns/1ps
module pffs_host (
	input  wire logic sys_clk,
	output logic      status_rd,
	output logic      port1_error_clear
);
	initial begin
		status_rd = 1'b0;
		port1_error_clear = 1'b0;
	end

	// One-cycle read or error-clear pulse, launched after an edge
	task automatic pulse(input logic clr);
		@(posedge sys_clk);
		#2;
		if (clr)
			port1_error_clear = 1'b1;
		else
			status_rd = 1'b1;
		@(posedge sys_clk);
		#2;
		status_rd = 1'b0;
		port1_error_clear = 1'b0;
	endtask
endmodule

/* tb/port_fault_status_flags_bench.sv */
`timescale 1ns/1ps
module port_fault_status_flags_bench;
	import pffs_pkg::*;
	logic       sys_clk, rst_b, lv, ot, ov, df, pe, slp;
	logic       rd, eclr, valid, err, a1, a1e, a2, a2e;
	logic [7:0] rdata;
	logic [7:0] exp_q[$];
	int         error_cnt, samples_checked, m;
	logic [7:0] fbit [4] = '{8'h10, 8'h08, 8'h04, 8'h40};
	logic [1:0] falr [4] = '{2'b10, 2'b11, 2'b11, 2'b10};

	pffs_flags uut (
		.sys_clk(sys_clk), .rst_b(rst_b),
		.port1_low_voltage_in(lv), .die_overtemp_in(ot),
		.supply_overvoltage_in(ov), .port1_discharge_fail_in(df),
		.power_enable_control(pe), .sleep_mode(slp),
		.status_rd(rd), .port1_error_clear(eclr),
		.status_rd_data(rdata), .status_rd_valid(valid),
		.port1_error_bit(err), .alert1_o(a1), .alert1_oe(a1e),
		.alert2_o(a2), .alert2_oe(a2e)
	);

	pffs_host u_host (
		.sys_clk(sys_clk), .status_rd(rd), .port1_error_clear(eclr)
	);

	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic give_verdict();
		if (exp_q.size() != 0)
			error_cnt++;
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	task automatic rd_exp(input logic [7:0] exp);
		exp_q.push_back(exp);
		u_host.pulse(1'b0);
	endtask

	// Alert levels stay low; expect {alert1_oe, alert2_oe, error}
	task automatic pins(input logic [2:0] exp);
		chk({3'h0, a1, a2, a1e, a2e, err}, {5'h00, exp});
	endtask

	task automatic reset_dut(input int n);
		rst_b = 1'b0;
		repeat (n) @(posedge sys_clk);
		#2;
		rst_b = 1'b1;
	endtask

	always @(posedge sys_clk) begin
		if (valid === 1'b1) begin
			if (exp_q.size() == 0)
				chk(rdata, 8'hFF);
			else
				chk(rdata, exp_q.pop_front());
		end
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		error_cnt++;
		give_verdict();
	end

	initial begin
		{lv, ot, ov, df, pe, slp} = 6'h00;
		error_cnt = 0;
		samples_checked = 0;
		void'($urandom(32'h42CA4E54));
		reset_dut(12);
		pins(3'b000);
		rd_exp(8'h20);
		rd_exp(8'h00);
		cyc(2);
		reset_dut(2);
		slp = 1'b1;
		rd_exp(8'h20);
		pe = 1'b1;
		cyc(6);
		rd_exp(8'h20);
		slp = 1'b0;
		pe = 1'b0;
		cyc(6);
		rd_exp(8'h00);
		// Each fault source in turn, random clearing path
		for (int i = 0; i < 4; i++) begin
			m = $urandom % 2;
			{lv, ot, ov, df} = 4'h8 >> i;
			cyc(5);
			pins({falr[i], 1'b1});
			rd_exp(8'h80 | fbit[i]);
			rd_exp(8'h80 | fbit[i]);
			u_host.pulse(1'b1);
			cyc(2);
			pins({falr[i], 1'b1});
			{lv, ot, ov, df} = 4'h0;
			cyc(4);
			if (m == 0) begin
				rd_exp(8'h80 | fbit[i]);
				pins(3'b001);
			end
			u_host.pulse(1'b1);
			cyc(2);
			pins(3'b000);
			rd_exp(8'h00);
		end
		cyc(3);
		give_verdict();
	end
endmodule
